//--- spsm_pkg.sv
// Shared constants and carrier types for the storage power state manager.
// Assumes a single 250 MHz clock domain; no register bus reaches this block.
package spsm_pkg;

  // ==========================================================================
  // Clock and channel geometry
  // ==========================================================================
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned NDEV       = 2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // Recommended ceiling on a D1 to D0 return, and its cycle count (exact product, no rounding)
  localparam int unsigned RESUME_MAX_MS  = 5000;
  localparam int unsigned RESUME_MAX_CYC = RESUME_MAX_MS * CLK_MHZ * 1000;
  // Shared channel reset pulse on a wake out of D3 (least time, round up)
  localparam int unsigned CHAN_RST_NS    = 2000;
  localparam int unsigned CHAN_RST_CYC   = (CHAN_RST_NS * CLK_MHZ + 999) / 1000;
  // Plain defaults for the idle timeouts; the real values are a system choice
  localparam int unsigned STANDBY_IDLE_MS = 1000;
  localparam int unsigned SLEEP_IDLE_MS   = 4000;
  localparam int unsigned STANDBY_IDLE_CYC = STANDBY_IDLE_MS * CLK_MHZ * 1000;
  localparam int unsigned SLEEP_IDLE_CYC   = SLEEP_IDLE_MS * CLK_MHZ * 1000;

  // ==========================================================================
  // Power state field codes
  // ==========================================================================
  localparam logic [1:0] PCODE_D0 = 2'h0;
  localparam logic [1:0] PCODE_D1 = 2'h1;
  localparam logic [1:0] PCODE_D2 = 2'h2;
  localparam logic [1:0] PCODE_D3 = 2'h3;

  // ==========================================================================
  // States and carriers
  // ==========================================================================
  typedef enum logic [1:0] {SPSM_D0, SPSM_D1, SPSM_D3} spsm_dev_t;
  typedef enum logic [1:0] {SPSM_CH_D0, SPSM_CH_RST, SPSM_CH_D3} spsm_chan_t;

  typedef struct packed {
    logic floppy;
    logic d1_cap;
    logic fast_cap;
    logic removable;
  } spsm_cfg_t;

  typedef struct packed {
    logic       ctrl_on;
    logic       timing_valid;
    logic       spin_on;
    logic       fast_start;
    logic       laser_en;
    logic       resuming;
    logic       resume_late;
    logic       wake;
    logic [1:0] pstate;
  } spsm_dev_out_t;

  typedef struct packed {
    logic       on;
    logic       timing_valid;
    logic       bus_power;
    logic       reset;
    logic [1:0] pstate;
  } spsm_chan_out_t;

endpackage

//--- spsm_idle_timer.sv
// Idle timer for one drive: counts cycles since its last high-priority I/O or the end of a channel reset.
// Assumes i_clear is a same-clock pulse; both thresholds are nonzero.
`timescale 1ns/1ps
module spsm_idle_timer #(
  parameter int unsigned STANDBY_CYC = spsm_pkg::STANDBY_IDLE_CYC,
  parameter int unsigned SLEEP_CYC   = spsm_pkg::SLEEP_IDLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clear,
  output logic      o_standby_hit,
  output logic      o_sleep_hit
);
  import spsm_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  // Sleep limit never below the standby limit
  localparam logic [31:0] STBY_LIM  = 32'(STANDBY_CYC);
  localparam logic [31:0] SLEEP_LIM = (SLEEP_CYC < STANDBY_CYC) ? 32'(STANDBY_CYC) : 32'(SLEEP_CYC);

  typedef struct packed {
    logic [31:0] cnt;
    logic        stby;
    logic        slp;
  } spsm_tmr_t;

  spsm_tmr_t s;
  spsm_tmr_t next_s;

  always_comb begin
    next_s = s;
    if (i_clear) begin
      next_s = '0;
    end else if (s.cnt != SLEEP_LIM) begin
      // Saturates, so a long idle spell never wraps back to busy
      next_s.cnt = s.cnt + 32'h1;
    end
    next_s.stby = !i_clear && (next_s.cnt >= STBY_LIM);
    next_s.slp  = !i_clear && (next_s.cnt >= SLEEP_LIM);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_standby_hit = s.stby;
  assign o_sleep_hit   = s.slp;

endmodule

//--- spsm_top.sv
// Power state manager for one storage channel: the drives on it and its adapter.
// Assumes same-clock request pulses from the host side; media sense is a raw pin.
//
// Contract
// - In D0 the drive interface and control logic work with timing context programmed.
// - D1 keeps interface timing context and working controller logic.
// - In D1 the spindle stops, fast-start enabled if offered, laser off.
// - Return from D1 to D0 should take under five seconds; recommendation only.
// - In D3 controller is off, all context lost, spindle stopped, laser off.
// - No D2 anywhere; floppy and channel adapter have no D1 either.
// - A floppy in D0 keeps controller working and spindle turning.
// - Adapter in D0 works, timing programmed, powers the bus and all drives.
// - Adapter in D3 is off, loses timing, may cut bus power.
// - A drive in D3 returns to D0 on high-priority I/O.
// - D1-capable drive in D0 enters D1 after standby idle timeout.
// - Drive enters D3 on system sleep or sleep idle timeout, not below standby.
// - A drive in D1 returns to D0 on high-priority I/O.
// - Leaving D3 needs a channel reset, so both drives enter D3 together.
// - Adapter leaves D3 when any drive needs a state other than D3.
// - Adapter leaves D0 for D3 only when every drive is in D3.
// - Removable drives may signal wake on media insertion; no other wake.
// - Disk, CD and removable drives support D0 and D3, D1 optional.
`timescale 1ns/1ps
module spsm_top #(
  parameter int unsigned NDEV         = spsm_pkg::NDEV,
  parameter int unsigned STANDBY_CYC  = spsm_pkg::STANDBY_IDLE_CYC,
  parameter int unsigned SLEEP_CYC    = spsm_pkg::SLEEP_IDLE_CYC,
  parameter int unsigned RESUME_CYC   = spsm_pkg::RESUME_MAX_CYC,
  parameter int unsigned CHAN_RST_CYC = spsm_pkg::CHAN_RST_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire spsm_pkg::spsm_cfg_t       i_cfg          [NDEV],
  input  wire logic [NDEV-1:0]           i_hp_io,
  input  wire logic                      i_sys_sleep,
  input  wire logic [NDEV-1:0]           i_timing_load,
  input  wire logic                      i_chan_timing_load,
  input  wire logic [NDEV-1:0]           i_spin_ready,
  input  wire logic [NDEV-1:0]           i_media_ins,
  output spsm_pkg::spsm_dev_out_t        o_dev          [NDEV],
  output spsm_pkg::spsm_chan_out_t       o_chan
);
  import spsm_pkg::*;

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [31:0] RES_LAST = 32'(RESUME_CYC - 1);
  localparam logic [15:0] RST_LAST = 16'(CHAN_RST_CYC - 1);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    spsm_dev_t  [NDEV-1:0]       dev;
    logic       [NDEV-1:0]       tvalid;
    logic       [NDEV-1:0]       resuming;
    logic       [NDEV-1:0]       late;
    logic       [NDEV-1:0][31:0] res_cnt;
    logic       [NDEV-1:0][2:0]  ins_sync;
    logic       [NDEV-1:0]       ins_level;
    logic       [NDEV-1:0]       wake;
    spsm_chan_t                  chan;
    logic                        ctvalid;
    logic                        pend;
    logic       [15:0]           rst_cnt;
  } spsm_state_t;

  spsm_state_t s;
  spsm_state_t next_s;

  logic [NDEV-1:0] t1_hit;
  logic [NDEV-1:0] t2_hit;
  logic [NDEV-1:0] tmr_clr;
  logic [NDEV-1:0] dev_d3;
  logic [NDEV-1:0] d1_ok;
  logic            all_d3;
  logic            go_d3;
  logic            rst_done;
  logic            wake_req;

  // ==========================================================================
  // Idle timers, one per drive
  // ==========================================================================
  for (genvar g = 0; g < NDEV; g++) begin : g_tmr
    spsm_idle_timer #(
      .STANDBY_CYC (STANDBY_CYC),
      .SLEEP_CYC   (SLEEP_CYC)
    ) u_tmr (
      .i_clk         (i_clk),
      .i_rst_b       (i_rst_b),
      .i_clear       (tmr_clr[g]),
      .o_standby_hit (t1_hit[g]),
      .o_sleep_hit   (t2_hit[g])
    );

    assign dev_d3[g]  = (s.dev[g] == SPSM_D3);
    // Floppies never use D1; other drives only when they offer it
    assign d1_ok[g]   = i_cfg[g].d1_cap && !i_cfg[g].floppy;
    assign tmr_clr[g] = i_hp_io[g] || rst_done;
  end

  // ==========================================================================
  // Channel-wide decisions
  // ==========================================================================
  assign all_d3   = &dev_d3;
  assign rst_done = (s.chan == SPSM_CH_RST) && (s.rst_cnt == RST_LAST);
  // Whole channel sleeps at once, since only a shared reset brings it back
  assign go_d3    = (s.chan == SPSM_CH_D0) && !all_d3 &&
                    (i_sys_sleep || ((&t2_hit) && !(|i_hp_io)));
  // I/O that finds the channel asleep or falling asleep is held until served
  assign wake_req = (|i_hp_io) && (go_d3 || all_d3 || (s.chan == SPSM_CH_D3));

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s = s;

    // ------------------------------------------------------------------------
    // Per-drive power state
    // ------------------------------------------------------------------------
    for (int d = 0; d < NDEV; d++) begin
      unique case (s.dev[d])
        SPSM_D0: begin
          if (go_d3) begin
            next_s.dev[d] = SPSM_D3;
          end else if (t1_hit[d] && d1_ok[d] && !i_hp_io[d]) begin
            next_s.dev[d] = SPSM_D1;
          end
        end
        SPSM_D1: begin
          if (go_d3) begin
            next_s.dev[d] = SPSM_D3;
          end else if (i_hp_io[d]) begin
            next_s.dev[d]      = SPSM_D0;
            next_s.resuming[d] = 1'b1;
            next_s.late[d]     = 1'b0;
            next_s.res_cnt[d]  = '0;
          end
        end
        SPSM_D3: begin
          // Only the end of the shared reset brings a drive back
          if (rst_done) begin
            next_s.dev[d] = SPSM_D0;
          end
        end
        default: begin
          next_s.dev[d] = SPSM_D0;
        end
      endcase

      // Spin-up watch after D1; a slow drive is flagged, never blocked
      if (s.resuming[d]) begin
        if (i_spin_ready[d] || (next_s.dev[d] != SPSM_D0)) begin
          next_s.resuming[d] = 1'b0;
        end else if (s.res_cnt[d] == RES_LAST) begin
          next_s.resuming[d] = 1'b0;
          next_s.late[d]     = 1'b1;
        end else begin
          next_s.res_cnt[d] = s.res_cnt[d] + 32'h1;
        end
      end

      // Interface timing context: loaded while awake, kept in D1, lost in D3
      if (i_timing_load[d] && (s.chan == SPSM_CH_D0) && (s.dev[d] == SPSM_D0)) begin
        next_s.tvalid[d] = 1'b1;
      end
      if (next_s.dev[d] == SPSM_D3 || rst_done) begin
        next_s.tvalid[d] = 1'b0;
      end

      // Media sense: three flops, a change counts once the last two agree
      next_s.ins_sync[d] = {s.ins_sync[d][1:0], i_media_ins[d]};
      next_s.wake[d]     = 1'b0;
      if (s.ins_sync[d][1] == s.ins_sync[d][2]) begin
        next_s.ins_level[d] = s.ins_sync[d][2];
        next_s.wake[d]      = s.ins_sync[d][2] && !s.ins_level[d] &&
                              i_cfg[d].removable && (s.dev[d] != SPSM_D0);
      end
    end

    // ------------------------------------------------------------------------
    // Channel adapter
    // ------------------------------------------------------------------------
    unique case (s.chan)
      SPSM_CH_D0: begin
        if (i_chan_timing_load) begin
          next_s.ctvalid = 1'b1;
        end
        if (all_d3) begin
          next_s.chan    = SPSM_CH_D3;
          next_s.ctvalid = 1'b0;
        end
      end
      SPSM_CH_D3: begin
        next_s.ctvalid = 1'b0;
        if (s.pend && !i_sys_sleep) begin
          next_s.chan    = SPSM_CH_RST;
          next_s.rst_cnt = '0;
        end
      end
      SPSM_CH_RST: begin
        if (rst_done) begin
          next_s.chan = SPSM_CH_D0;
        end else begin
          next_s.rst_cnt = s.rst_cnt + 16'h1;
        end
      end
      default: begin
        next_s.chan = SPSM_CH_D0;
      end
    endcase

    // Pending wake: a fresh request wins over the clear in the same cycle
    if (s.chan == SPSM_CH_D3 && next_s.chan == SPSM_CH_RST) begin
      next_s.pend = 1'b0;
    end
    if (wake_req) begin
      next_s.pend = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  for (genvar g = 0; g < NDEV; g++) begin : g_out
    always_comb begin
      o_dev[g].ctrl_on      = (s.dev[g] != SPSM_D3) && (s.chan == SPSM_CH_D0);
      o_dev[g].timing_valid = s.tvalid[g];
      o_dev[g].spin_on      = (s.dev[g] == SPSM_D0);
      o_dev[g].fast_start   = (s.dev[g] == SPSM_D1) && i_cfg[g].fast_cap;
      o_dev[g].laser_en     = (s.dev[g] == SPSM_D0) && !i_cfg[g].floppy;
      o_dev[g].resuming     = s.resuming[g];
      o_dev[g].resume_late  = s.late[g];
      o_dev[g].wake         = s.wake[g];
      unique case (s.dev[g])
        SPSM_D1: o_dev[g].pstate = PCODE_D1;
        SPSM_D3: o_dev[g].pstate = PCODE_D3;
        default: o_dev[g].pstate = PCODE_D0;
      endcase
    end
  end

  always_comb begin
    o_chan.on           = (s.chan == SPSM_CH_D0);
    o_chan.timing_valid = s.ctvalid;
    // Bus power is cut only while asleep; the reset pulse runs powered
    o_chan.bus_power    = (s.chan != SPSM_CH_D3);
    o_chan.reset        = (s.chan == SPSM_CH_RST);
    o_chan.pstate       = (s.chan == SPSM_CH_D3) ? PCODE_D3 : PCODE_D0;
  end

endmodule

//--- spsm_top_sva.sv
// Checker for the storage power state manager, watching top ports only.
// Assumes one clock domain; the shortened reset count is handed on by bind.
`timescale 1ns/1ps
module spsm_top_sva #(
  parameter int unsigned NDEV         = 2,
  parameter int unsigned CHAN_RST_CYC = 4
) (
  input wire logic                     i_clk,
  input wire logic                     i_rst_b,
  input wire spsm_pkg::spsm_cfg_t      i_cfg              [NDEV],
  input wire logic [NDEV-1:0]          i_hp_io,
  input wire logic                     i_sys_sleep,
  input wire logic [NDEV-1:0]          i_timing_load,
  input wire logic                     i_chan_timing_load,
  input wire logic [NDEV-1:0]          i_spin_ready,
  input wire logic [NDEV-1:0]          i_media_ins,
  input wire spsm_pkg::spsm_dev_out_t  o_dev              [NDEV],
  input wire spsm_pkg::spsm_chan_out_t o_chan
);
  import spsm_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================================
  // Channel reset length, counted rather than repeated
  // ==========================================================================
  logic [15:0] rst_cnt;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) rst_cnt <= 16'h0;
    else rst_cnt <= o_chan.reset ? rst_cnt + 16'h1 : 16'h0;
  end
  a_rst_len_exact:
    assert property ($fell(o_chan.reset) |-> rst_cnt == 16'(CHAN_RST_CYC)) else $error("channel reset length wrong");
  a_chan_off_dark:
    assert property (o_chan.pstate == PCODE_D3 && !o_chan.reset |-> !o_chan.on && !o_chan.timing_valid
      && !o_chan.bus_power) else $error("channel off state outputs wrong");
  a_chan_on_power:
    assert property (o_chan.on |-> o_chan.bus_power && o_chan.pstate == PCODE_D0) else $error("channel power wrong");
  for (genvar g = 0; g < NDEV; g++) begin : g_dev
    a_d3_dark:
      assert property (o_dev[g].pstate == PCODE_D3 |-> !o_dev[g].ctrl_on && !o_dev[g].timing_valid
        && !o_dev[g].spin_on && !o_dev[g].laser_en) else $error("drive off state outputs wrong");
    a_d1_kept_live:
      assert property (o_dev[g].pstate == PCODE_D1 |-> o_dev[g].ctrl_on && !o_dev[g].spin_on && !o_dev[g].laser_en
        && o_dev[g].fast_start == i_cfg[g].fast_cap) else $error("drive standby outputs wrong");
    a_d0_live:
      assert property (o_dev[g].pstate == PCODE_D0 && o_chan.on |-> o_dev[g].ctrl_on && o_dev[g].spin_on
        && o_dev[g].laser_en == !i_cfg[g].floppy) else $error("drive active outputs wrong");
    a_state_legal:
      assert property (o_dev[g].pstate != PCODE_D2 && !((i_cfg[g].floppy || !i_cfg[g].d1_cap)
        && o_dev[g].pstate == PCODE_D1)) else $error("drive state not supported");
    a_d3_exit_d0:
      assert property ($past(o_dev[g].pstate) == PCODE_D3 |-> o_dev[g].pstate != PCODE_D1) else $error("bad exit");
    a_d1_wake_io:
      assert property (o_dev[g].pstate == PCODE_D1 && i_hp_io[g] && !i_sys_sleep |=> o_dev[g].pstate == PCODE_D0)
        else $error("standby drive did not resume");
    a_sleep_all_d3:
      assert property (o_chan.on && i_sys_sleep |=> o_dev[g].pstate == PCODE_D3) else $error("sleep entry missed");
    a_chan_d3_all:
      assert property (o_chan.pstate == PCODE_D3 && !o_chan.reset |-> o_dev[g].pstate == PCODE_D3)
        else $error("channel off with live drive");
    a_rst_wakes_all:
      assert property ($fell(o_chan.reset) |-> ##[0:1] (o_chan.on && o_dev[g].pstate == PCODE_D0))
        else $error("channel reset left drive asleep");
    a_wake_source:
      assert property (o_dev[g].wake |-> i_cfg[g].removable ##1 !o_dev[g].wake) else $error("bad wake pulse");
  end
  c_standby: cover property (o_dev[0].pstate == PCODE_D1);
  c_chan_off: cover property (o_chan.pstate == PCODE_D3);
  c_chan_wake: cover property ($fell(o_chan.reset));
  c_media: cover property (o_dev[0].wake);
endmodule

bind spsm_top spsm_top_sva #(.NDEV(NDEV), .CHAN_RST_CYC(CHAN_RST_CYC)) u_spsm_top_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_hp_io(i_hp_io), .i_sys_sleep(i_sys_sleep),
  .i_timing_load(i_timing_load), .i_chan_timing_load(i_chan_timing_load), .i_spin_ready(i_spin_ready),
  .i_media_ins(i_media_ins), .o_dev(o_dev), .o_chan(o_chan));

//--- spsm_host_model.sv
// Host and drive side model: reloads drive timing, reports spindle up.
// Assumes the top's drive outputs; i_slow picks a reply past the resume limit.
`timescale 1ns/1ps
module spsm_host_model #(
  parameter int unsigned NDEV     = 2,
  parameter int unsigned FAST_CYC = 2,
  parameter int unsigned SLOW_CYC = 60
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_slow,
  input  wire spsm_pkg::spsm_dev_out_t i_dev         [NDEV],
  output logic [NDEV-1:0]              o_spin_ready,
  output logic [NDEV-1:0]              o_timing_load
);
  import spsm_pkg::*;
  int unsigned wait_cnt [NDEV];
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_spin_ready <= '0;
      o_timing_load <= '0;
      for (int d = 0; d < NDEV; d++) wait_cnt[d] <= 0;
    end else begin
      for (int d = 0; d < NDEV; d++) begin
        // Host reprograms timing once a live drive has lost it
        o_timing_load[d] <= i_dev[d].ctrl_on && i_dev[d].pstate == PCODE_D0 && !i_dev[d].timing_valid
                            && !o_timing_load[d];
        wait_cnt[d] <= i_dev[d].resuming ? wait_cnt[d] + 1 : 0;
        // Slow spin-up is real drive behaviour, not a fault
        o_spin_ready[d] <= i_dev[d].resuming && (wait_cnt[d] >= (i_slow ? SLOW_CYC : FAST_CYC));
      end
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the storage power state manager.
// Assumes shortened counts; drive 0 is a removable disk, drive 1 a floppy.
`timescale 1ns/1ps
module tb;
  import spsm_pkg::*;
  localparam int unsigned SB = 20, SL = 40, RS = 12, CR = 4, FAST = 2, SLOW = 60;
  logic           i_clk, i_rst_b, i_sys_sleep, i_chan_timing_load, slow;
  logic [1:0]     i_hp_io, i_timing_load, i_spin_ready, i_media_ins;
  logic [31:0]    m;
  spsm_cfg_t      i_cfg  [2];
  spsm_dev_out_t  o_dev  [2];
  spsm_chan_out_t o_chan;
  int             err_total, n_checks, cyc, seed, n, k, w0, w1;
  spsm_top #(.NDEV(2), .STANDBY_CYC(SB), .SLEEP_CYC(SL), .RESUME_CYC(RS), .CHAN_RST_CYC(CR)) u_spsm_top (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_hp_io(i_hp_io), .i_sys_sleep(i_sys_sleep),
    .i_timing_load(i_timing_load), .i_chan_timing_load(i_chan_timing_load), .i_spin_ready(i_spin_ready),
    .i_media_ins(i_media_ins), .o_dev(o_dev), .o_chan(o_chan));
  spsm_host_model #(.NDEV(2), .FAST_CYC(FAST), .SLOW_CYC(SLOW)) u_spsm_host_model (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow), .i_dev(o_dev), .o_spin_ready(i_spin_ready),
    .o_timing_load(i_timing_load));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic exp_laser(input spsm_cfg_t c, input logic [1:0] ps);
    return ps == PCODE_D0 && !c.floppy;
  endfunction
  function automatic logic exp_late(input int unsigned reply);
    return reply >= RS;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic hp(input logic [1:0] mk);
    i_hp_io = mk;
    tick(1);
    i_hp_io = 2'h0;
  endtask
  task automatic wait_ps(input int d, input logic [1:0] ps, input int lim);
    n = 0;
    while (((d < 0) ? o_chan.pstate : o_dev[d].pstate) !== ps && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 98;
    {err_total, n_checks, cyc} = '0;
    {i_rst_b, i_hp_io, i_sys_sleep, i_chan_timing_load, i_media_ins, slow} = '0;
    i_cfg[0] = '{floppy: 1'b0, d1_cap: 1'b1, fast_cap: 1'b1, removable: 1'b1};
    i_cfg[1] = '{floppy: 1'b1, d1_cap: 1'b0, fast_cap: 1'b0, removable: 1'b0};
    tick(6);
    i_rst_b = 1'b1;
    for (int d = 0; d < 2; d++) begin
      chk("pstate_rst", PCODE_D0, o_dev[d].pstate);
      chk("laser_rst", exp_laser(i_cfg[d], PCODE_D0), o_dev[d].laser_en);
    end
    chk("bus_rst", 1, o_chan.bus_power);
    i_chan_timing_load = 1'b1;
    tick(1);
    i_chan_timing_load = 1'b0;
    tick(4);
    chk("chan_tv", 1, o_chan.timing_valid);
    chk("dev_tv", 1, o_dev[0].timing_valid);
    // Random busy traffic, every gap shorter than the standby timeout
    for (int i = 0; i < 30; i++) begin
      m = $random(seed);
      hp(2'h3);
      tick(1 + m[2:0]);
    end
    chk("busy_d0", PCODE_D0, o_dev[0].pstate);
    wait_ps(0, PCODE_D1, SB + 10);
    // Cycles from the last request edge, so the random gap cannot skew it
    chk("d1_due", SB + 1, n + 1 + m[2:0]);
    chk("floppy_d0", PCODE_D0, o_dev[1].pstate);
    chk("d1_tv", 1, o_dev[0].timing_valid);
    chk("d1_fast", 1, o_dev[0].fast_start);
    hp(2'h1);
    chk("resume_d0", PCODE_D0, o_dev[0].pstate);
    chk("resuming", 1, o_dev[0].resuming);
    tick(RS + 5);
    chk("late_fast", exp_late(FAST), o_dev[0].resume_late);
    slow = 1'b1;
    hp(2'h3);
    wait_ps(0, PCODE_D1, SB + 10);
    hp(2'h1);
    tick(RS + 5);
    chk("late_slow", exp_late(SLOW), o_dev[0].resume_late);
    slow = 1'b0;
    wait_ps(-1, PCODE_D3, SL + 20);
    chk("idle_chan", PCODE_D3, o_chan.pstate);
    for (int d = 0; d < 2; d++) chk("idle_dev", PCODE_D3, o_dev[d].pstate);
    // Wake with a random delay, then time the shared channel reset
    m = $random(seed);
    tick(1 + m[2:0]);
    hp(2'h2);
    n = 0;
    while (o_chan.reset !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    k = 0;
    while (o_chan.reset === 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    chk("rst_len", CR, k);
    tick(1);
    for (int d = 0; d < 2; d++) chk("wake_dev", PCODE_D0, o_dev[d].pstate);
    chk("wake_chan", 1, o_chan.on);
    tick(2);
    i_sys_sleep = 1'b1;
    tick(1);
    for (int d = 0; d < 2; d++) chk("sleep_dev", PCODE_D3, o_dev[d].pstate);
    tick(1);
    chk("sleep_chan", PCODE_D3, o_chan.pstate);
    hp(2'h1);
    i_media_ins = 2'h3;
    {w0, w1} = '0;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      w0 += o_dev[0].wake;
      w1 += o_dev[1].wake;
    end
    chk("held_d3", PCODE_D3, o_chan.pstate);
    chk("wake_rem", 1, w0);
    chk("wake_fixed", 0, w1);
    i_media_ins = 2'h0;
    i_sys_sleep = 1'b0;
    wait_ps(0, PCODE_D0, CR + 12);
    tick(1);
    chk("late_wake", 1, o_chan.on);
    tick(5);
    summarize();
  end
endmodule
